// File: core/ufkv_defines.svh
// Constants for the user feedback key/value frame interpreter
`ifndef UFKV_DEFINES_SVH
`define UFKV_DEFINES_SVH

// Frame bytes, multi-byte fields sent low byte first
`define UFKV_HDR_LO 8'h01
`define UFKV_HDR_HI 8'h10
`define UFKV_TYPE_SET 8'h30
`define UFKV_TYPE_GET 8'h32
`define UFKV_LEN_SET 8'h05
`define UFKV_LEN_GET 8'h01
`define UFKV_SUM_INIT 16'h0000
`define UFKV_VAL_LAST 3'h3
`define UFKV_TX_CK_LO 4'h9
`define UFKV_TX_LAST 4'hA

// Keys
`define UFKV_KEY_MAX 8'h63
`define UFKV_KEY_USER_LO 8'h01
`define UFKV_KEY_MOTOR_L 8'h0A
`define UFKV_KEY_MOTOR_R 8'h0B
`define UFKV_KEY_MOTOR_BOTH 8'h0C
`define UFKV_KEY_INACT 8'h50
`define UFKV_KEY_AUTO_OFF 8'h51
`define UFKV_KEY_ORIENT 8'h52
`define UFKV_KEY_FREEFALL 8'h53
`define UFKV_KEY_INACT_EN 8'h54
`define UFKV_KEY_WDOG 8'h55
`define UFKV_KEY_DISP 8'h63

// Value limits and reset values
`define UFKV_ONE 32'h0000_0001
`define UFKV_INACT_MAX 32'h0000_000A
`define UFKV_DISP_MAX 32'h0000_0003
`define UFKV_SIX_MIN 32'hFFFE_7961
`define UFKV_SIX_MAX 32'h000F_423F
`define UFKV_PAUSE_RST 4'h1

// Timing
`define UFKV_CLK_KHZ 125000
`define UFKV_MOTOR_MS 750
`define UFKV_WDOG_MS 500

// APB register offsets and status bits
`define UFKV_OFS_KEY_SEL 8'h00
`define UFKV_OFS_KEY_VALUE 8'h04
`define UFKV_OFS_STATUS 8'h08
`define UFKV_OFS_DROP_CNT 8'h0C
`define UFKV_ST_ESTOP 0
`define UFKV_ST_WDOG_EN 1
`define UFKV_ST_RENDER_X 2
`define UFKV_ST_TX_BUSY 3
`define UFKV_ST_DISP_LO 4

`endif

// File: core/ufkv_pkg.sv
// Types and shared functions for the key/value frame interpreter
package ufkv_pkg;
`include "ufkv_defines.svh"

  typedef enum logic [7:0] {
    RX_H0 = 8'b0000_0001,
    RX_H1 = 8'b0000_0010,
    RX_TYPE = 8'b0000_0100,
    RX_LEN = 8'b0000_1000,
    RX_KEY = 8'b0001_0000,
    RX_VAL = 8'b0010_0000,
    RX_CK0 = 8'b0100_0000,
    RX_CK1 = 8'b1000_0000
  } rx_state_t;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } apb_req_t;

  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } apb_rsp_t;

  typedef struct packed {
    logic motor_left;
    logic motor_right;
    logic auto_off_en;
    logic orient_pause_en;
    logic freefall_pause_en;
    logic inact_pause_en;
    logic [3:0] inactivity_minutes_setting;
    logic [3:0] pause_minutes;
    logic [1:0] disp_mode;
  } remote_ctl_t;

  // One Fletcher step: sum1 in low byte, sum2 in high byte
  function automatic logic [15:0] fletcher_step(input logic [15:0] s, input logic [7:0] b);
    logic [7:0] s1;
    s1 = s[7:0] + b;
    return {s[15:8] + s1, s1};
  endfunction

  function automatic logic key_defined(input logic [7:0] k);
    return (k >= `UFKV_KEY_USER_LO && k <= `UFKV_KEY_MOTOR_BOTH) ||
           (k >= `UFKV_KEY_INACT && k <= `UFKV_KEY_WDOG) || (k == `UFKV_KEY_DISP);
  endfunction

  // Range check for configuration keys; feedback keys take any value
  function automatic logic value_allowed(input logic [7:0] k, input logic [31:0] v);
    if (k == `UFKV_KEY_INACT) return v <= `UFKV_INACT_MAX;
    if (k == `UFKV_KEY_DISP) return v <= `UFKV_DISP_MAX;
    if (k >= `UFKV_KEY_AUTO_OFF && k <= `UFKV_KEY_WDOG) return v <= `UFKV_ONE;
    return key_defined(k);
  endfunction

  // Six display characters cover -99999 to 999999
  function automatic logic fits_six(input logic [31:0] v);
    return ($signed(v) >= $signed(`UFKV_SIX_MIN)) && ($signed(v) <= $signed(`UFKV_SIX_MAX));
  endfunction
endpackage

// File: core/user_feedback_key_value_handler.sv
// Key/value feedback frame interpreter with APB status and key readback
`timescale 1ns/100ps
`include "ufkv_defines.svh"
module user_feedback_key_value_handler #(
  parameter int unsigned MOTOR_CYCLES = `UFKV_MOTOR_MS * `UFKV_CLK_KHZ,
  parameter int unsigned WDOG_CYCLES = `UFKV_WDOG_MS * `UFKV_CLK_KHZ
) (
  input wire logic mclk_in,
  input wire logic sys_rst_in,
  input wire logic [7:0] rx_byte_in,
  input wire logic rx_valid_in,
  output logic rx_ready_out,
  output logic [7:0] tx_byte_out,
  output logic tx_valid_out,
  input wire logic tx_ready_in,
  input wire logic hb_pulse_in,
  input wire logic nv_wdog_in,
  output logic nv_wr_out,
  output logic nv_wdog_out,
  output logic estop_out,
  output ufkv_pkg::remote_ctl_t remote_ctl_out,
  input wire ufkv_pkg::apb_req_t apb_req_in,
  output ufkv_pkg::apb_rsp_t apb_rsp_out
);
  import ufkv_pkg::*;

  localparam logic [26:0] MOTOR_CNT = 27'(MOTOR_CYCLES);
  localparam logic [25:0] WDOG_LAST = 26'(WDOG_CYCLES - 1);

  typedef struct packed {
    rx_state_t rx_st;
    logic [2:0] rx_cnt;
    logic [7:0] rx_type;
    logic [7:0] rx_key;
    logic [31:0] rx_val;
    logic [15:0] rx_sum;
    logic [7:0] rx_ck_lo;
    logic rx_ready;
    logic [99:0][31:0] store;
    logic tx_active;
    logic [3:0] tx_idx;
    logic [7:0] tx_key;
    logic [31:0] tx_val;
    logic [15:0] tx_sum;
    logic [7:0] tx_byte;
    logic tx_valid;
    logic [26:0] motor_l_cnt;
    logic [26:0] motor_r_cnt;
    remote_ctl_t ctl;
    logic [25:0] wd_cnt;
    logic estop;
    logic nv_loaded;
    logic nv_wr;
    logic [6:0] key_sel;
    logic [15:0] drop_cnt;
    apb_rsp_t rsp;
  } state_t;

  state_t r;
  state_t n;
  logic set_ok;
  logic get_ok;
  logic get_rej;
  logic frame_bad;

  // Outgoing set frame byte for a given position
  function automatic logic [7:0] tx_pick(input logic [3:0] idx, input logic [7:0] key,
                                         input logic [31:0] val, input logic [15:0] sum);
    case (idx)
      4'h0: return `UFKV_HDR_LO;
      4'h1: return `UFKV_HDR_HI;
      4'h2: return `UFKV_TYPE_SET;
      4'h3: return `UFKV_LEN_SET;
      4'h4: return key;
      4'h5: return val[7:0];
      4'h6: return val[15:8];
      4'h7: return val[23:16];
      4'h8: return val[31:24];
      4'h9: return sum[7:0];
      default: return sum[15:8];
    endcase
  endfunction

  // Whole next-state computation; reset is applied here so one always_ff suffices
  always_comb begin
    logic take;
    logic [7:0] b;
    logic [6:0] k;
    logic [31:0] sel_val;
    take = rx_valid_in & r.rx_ready;
    b = rx_byte_in;
    k = r.rx_key[6:0];
    sel_val = (r.key_sel <= `UFKV_KEY_MAX) ? r.store[r.key_sel] : 32'h0000_0000;
    n = r;
    set_ok = 1'b0;
    get_ok = 1'b0;
    get_rej = 1'b0;
    frame_bad = 1'b0;
    n.nv_wr = 1'b0;

    // Receive parser, checksum runs over every byte before the checksum
    if (take) begin
      case (r.rx_st)
        RX_H0: begin
          if (b == `UFKV_HDR_LO) begin
            n.rx_st = RX_H1;
            n.rx_sum = fletcher_step(`UFKV_SUM_INIT, b);
          end
        end
        RX_H1: begin
          if (b == `UFKV_HDR_HI) begin
            n.rx_st = RX_TYPE;
            n.rx_sum = fletcher_step(r.rx_sum, b);
          end else if (b == `UFKV_HDR_LO) begin
            n.rx_sum = fletcher_step(`UFKV_SUM_INIT, b); // Resync on a repeated low byte
          end else begin
            n.rx_st = RX_H0;
            frame_bad = 1'b1;
          end
        end
        RX_TYPE: begin
          n.rx_type = b;
          n.rx_sum = fletcher_step(r.rx_sum, b);
          // Other message types belong to other handlers and are not counted
          n.rx_st = (b == `UFKV_TYPE_SET || b == `UFKV_TYPE_GET) ? RX_LEN : RX_H0;
        end
        RX_LEN: begin
          n.rx_sum = fletcher_step(r.rx_sum, b);
          if ((r.rx_type == `UFKV_TYPE_SET && b == `UFKV_LEN_SET) ||
              (r.rx_type == `UFKV_TYPE_GET && b == `UFKV_LEN_GET)) begin
            n.rx_st = RX_KEY;
          end else begin
            n.rx_st = RX_H0;
            frame_bad = 1'b1;
          end
        end
        RX_KEY: begin
          n.rx_key = b;
          n.rx_cnt = 3'h0;
          n.rx_sum = fletcher_step(r.rx_sum, b);
          n.rx_st = (r.rx_type == `UFKV_TYPE_SET) ? RX_VAL : RX_CK0;
        end
        RX_VAL: begin
          n.rx_val = {b, r.rx_val[31:8]}; // Low byte first
          n.rx_sum = fletcher_step(r.rx_sum, b);
          n.rx_cnt = r.rx_cnt + 3'h1;
          if (r.rx_cnt == `UFKV_VAL_LAST) begin
            n.rx_st = RX_CK0;
          end
        end
        RX_CK0: begin
          n.rx_ck_lo = b;
          n.rx_st = RX_CK1;
        end
        RX_CK1: begin
          n.rx_st = RX_H0;
          if ({b, r.rx_ck_lo} != r.rx_sum || r.rx_key > `UFKV_KEY_MAX) begin
            frame_bad = 1'b1;
          end else if (r.rx_type == `UFKV_TYPE_SET) begin
            set_ok = value_allowed(r.rx_key, r.rx_val);
            frame_bad = !set_ok;
          end else begin
            get_ok = key_defined(r.rx_key);
            get_rej = !get_ok;
          end
        end
        default: n.rx_st = RX_H0;
      endcase
    end
    if (frame_bad) begin
      n.drop_cnt = r.drop_cnt + 16'h0001;
    end

    // Haptic pulse counters run down; a fresh write of 1 restarts the pulse
    if (r.motor_l_cnt != 27'h000_0000) begin
      n.motor_l_cnt = r.motor_l_cnt - 27'h000_0001;
    end
    if (r.motor_r_cnt != 27'h000_0000) begin
      n.motor_r_cnt = r.motor_r_cnt - 27'h000_0001;
    end

    // Store the value and act on keys with side effects
    if (set_ok) begin
      n.store[k] = r.rx_val;
      if (r.rx_val == `UFKV_ONE && (r.rx_key == `UFKV_KEY_MOTOR_L ||
                                    r.rx_key == `UFKV_KEY_MOTOR_BOTH)) begin
        n.motor_l_cnt = MOTOR_CNT;
      end
      if (r.rx_val == `UFKV_ONE && (r.rx_key == `UFKV_KEY_MOTOR_R ||
                                    r.rx_key == `UFKV_KEY_MOTOR_BOTH)) begin
        n.motor_r_cnt = MOTOR_CNT;
      end
      if (r.rx_key == `UFKV_KEY_WDOG) begin
        n.nv_wr = 1'b1;
      end
    end
    n.ctl.motor_left = n.motor_l_cnt != 27'h000_0000;
    n.ctl.motor_right = n.motor_r_cnt != 27'h000_0000;
    n.ctl.inactivity_minutes_setting = n.store[`UFKV_KEY_INACT][3:0];
    n.ctl.pause_minutes = n.store[`UFKV_KEY_INACT][3:0] + `UFKV_PAUSE_RST;
    n.ctl.auto_off_en = n.store[`UFKV_KEY_AUTO_OFF][0];
    n.ctl.orient_pause_en = n.store[`UFKV_KEY_ORIENT][0];
    n.ctl.freefall_pause_en = n.store[`UFKV_KEY_FREEFALL][0];
    n.ctl.inact_pause_en = n.store[`UFKV_KEY_INACT_EN][0];
    n.ctl.disp_mode = n.store[`UFKV_KEY_DISP][1:0];

    // Non-volatile watchdog enable is taken once, the cycle after reset release
    if (!r.nv_loaded) begin
      n.nv_loaded = 1'b1;
      n.store[`UFKV_KEY_WDOG] = 32'(nv_wdog_in);
    end

    // Host heartbeat watchdog; a late heartbeat clears the stop again
    if (!r.store[`UFKV_KEY_WDOG][0]) begin
      n.wd_cnt = 26'h000_0000;
      n.estop = 1'b0;
    end else if (hb_pulse_in) begin
      n.wd_cnt = 26'h000_0000;
      n.estop = 1'b0;
    end else if (r.wd_cnt == WDOG_LAST) begin
      n.estop = 1'b1;
    end else begin
      n.wd_cnt = r.wd_cnt + 26'h000_0001;
    end

    // Reply serializer; only one reply in flight, receive stalls meanwhile
    if (get_ok) begin
      n.tx_active = 1'b1;
      n.tx_key = r.rx_key;
      n.tx_val = r.store[k];
      n.tx_idx = 4'h0;
      n.tx_sum = `UFKV_SUM_INIT;
    end else if (r.tx_active && (!r.tx_valid || tx_ready_in)) begin
      if (r.tx_idx <= `UFKV_TX_LAST) begin
        n.tx_byte = tx_pick(r.tx_idx, r.tx_key, r.tx_val, r.tx_sum);
        n.tx_valid = 1'b1;
        if (r.tx_idx < `UFKV_TX_CK_LO) begin
          n.tx_sum = fletcher_step(r.tx_sum, n.tx_byte);
        end
        n.tx_idx = r.tx_idx + 4'h1;
      end else begin
        n.tx_valid = 1'b0;
        n.tx_active = 1'b0;
      end
    end else if (r.tx_valid && tx_ready_in) begin
      n.tx_valid = 1'b0;
    end
    n.rx_ready = !n.tx_active;

    // APB slave: answer is prepared in setup and presented through the access cycle
    n.rsp.pready = apb_req_in.psel & !apb_req_in.penable;
    n.rsp.pslverr = 1'b0;
    n.rsp.prdata = 32'h0000_0000;
    if (apb_req_in.psel && !apb_req_in.penable) begin
      case (apb_req_in.paddr)
        `UFKV_OFS_KEY_SEL: n.rsp.prdata = 32'(r.key_sel);
        `UFKV_OFS_KEY_VALUE: n.rsp.prdata = sel_val;
        `UFKV_OFS_STATUS: begin
          n.rsp.prdata[`UFKV_ST_ESTOP] = r.estop;
          n.rsp.prdata[`UFKV_ST_WDOG_EN] = r.store[`UFKV_KEY_WDOG][0];
          n.rsp.prdata[`UFKV_ST_RENDER_X] = !fits_six(sel_val);
          n.rsp.prdata[`UFKV_ST_TX_BUSY] = r.tx_active;
          n.rsp.prdata[`UFKV_ST_DISP_LO +: 2] = r.ctl.disp_mode;
        end
        `UFKV_OFS_DROP_CNT: n.rsp.prdata = 32'(r.drop_cnt);
        default: n.rsp.pslverr = 1'b1;
      endcase
    end
    if (apb_req_in.psel && apb_req_in.penable && r.rsp.pready && apb_req_in.pwrite &&
        apb_req_in.paddr == `UFKV_OFS_KEY_SEL) begin
      n.key_sel = apb_req_in.pwdata[6:0];
    end

    // Synchronous reset to documented defaults
    if (sys_rst_in) begin
      n = '0;
      n.rx_st = RX_H0;
      n.rx_ready = 1'b1;
      n.store[`UFKV_KEY_AUTO_OFF] = `UFKV_ONE;
      n.store[`UFKV_KEY_ORIENT] = `UFKV_ONE;
      n.store[`UFKV_KEY_FREEFALL] = `UFKV_ONE;
      n.store[`UFKV_KEY_INACT_EN] = `UFKV_ONE;
      n.ctl.auto_off_en = 1'b1;
      n.ctl.orient_pause_en = 1'b1;
      n.ctl.freefall_pause_en = 1'b1;
      n.ctl.inact_pause_en = 1'b1;
      n.ctl.pause_minutes = `UFKV_PAUSE_RST;
    end
  end

  // State register
  always_ff @(posedge mclk_in) begin
    r <= n;
  end

  // Outputs straight from state
  assign rx_ready_out = r.rx_ready;
  assign tx_byte_out = r.tx_byte;
  assign tx_valid_out = r.tx_valid;
  assign nv_wr_out = r.nv_wr;
  assign nv_wdog_out = r.store[`UFKV_KEY_WDOG][0];
  assign estop_out = r.estop;
  assign remote_ctl_out = r.ctl;
  assign apb_rsp_out = r.rsp;

  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (sys_rst_in);

  chk_set_store:
    assert property (set_ok |=> r.store[$past(r.rx_key[6:0])] == $past(r.rx_val))
      else $error("set frame value not stored");
  chk_bad_frame:
    assert property (frame_bad |=> r.store == $past(r.store))
      else $error("discarded frame changed the store");
  chk_get_reply:
    assert property (get_ok |=> r.tx_active && r.tx_key == $past(r.rx_key) ##1
                     tx_valid_out && tx_byte_out == `UFKV_HDR_LO)
      else $error("get frame did not start a reply");
  chk_undef_get:
    assert property (get_rej && !r.tx_active |=> !r.tx_active)
      else $error("undefined key produced a reply");
  chk_motor_time:
    assert property ($rose(r.ctl.motor_left) |-> r.motor_l_cnt == MOTOR_CNT)
      else $error("left motor pulse length wrong");
  chk_motor_both:
    assert property (set_ok && r.rx_key == `UFKV_KEY_MOTOR_BOTH && r.rx_val == `UFKV_ONE
                     |=> remote_ctl_out.motor_left && remote_ctl_out.motor_right)
      else $error("both motors not pulsed");
  chk_motor_right:
    assert property (set_ok && r.rx_key == `UFKV_KEY_MOTOR_R && r.rx_val == `UFKV_ONE
                     |=> remote_ctl_out.motor_right && r.motor_r_cnt == MOTOR_CNT)
      else $error("right motor not pulsed");
  chk_wdog_trip:
    assert property (r.store[`UFKV_KEY_WDOG][0] && r.wd_cnt == WDOG_LAST && !hb_pulse_in
                     |=> estop_out)
      else $error("watchdog did not flag stop");
  chk_wdog_off:
    assert property (!r.store[`UFKV_KEY_WDOG][0] |=> !estop_out)
      else $error("stop flagged with watchdog disabled");
  chk_nv_write:
    assert property (set_ok && r.rx_key == `UFKV_KEY_WDOG
                     |=> nv_wr_out && nv_wdog_out == $past(r.rx_val[0]))
      else $error("watchdog enable not written to storage");
  chk_inact_range:
    assert property (remote_ctl_out.pause_minutes == remote_ctl_out.inactivity_minutes_setting
                     + `UFKV_PAUSE_RST && r.store[`UFKV_KEY_INACT] <= `UFKV_INACT_MAX)
      else $error("inactivity setting out of range");
endmodule // user_feedback_key_value_handler

// File: bench/host_link_model.sv
// Host computer model for the frame receive link and the reply link
`timescale 1ns/100ps
module host_link_model (
  input wire logic mclk_in,
  input wire logic rx_ready_in,
  output logic [7:0] rx_byte_out,
  output logic rx_valid_out,
  input wire logic [7:0] tx_byte_in,
  input wire logic tx_valid_in,
  output logic tx_ready_out
);
  logic slow = 1'b0;
  logic [7:0] got[$];

  initial begin
    rx_byte_out = 8'h00;
    rx_valid_out = 1'b0;
    tx_ready_out = 1'b1;
  end

  // Each byte is held until taken; idle data shows the inverse so stale bytes cannot pass
  task automatic send(input logic [7:0] f[$]);
    foreach (f[i]) begin
      rx_byte_out <= f[i];
      rx_valid_out <= 1'b1;
      @(posedge mclk_in);
      while (rx_ready_in !== 1'b1) @(posedge mclk_in);
    end
    rx_valid_out <= 1'b0;
    rx_byte_out <= ~f[f.size()-1];
  endtask

  // Reply sink; slow mode stalls every other cycle to exercise the hold
  always @(posedge mclk_in) begin
    if (tx_valid_in && tx_ready_out) got.push_back(tx_byte_in);
    tx_ready_out <= slow ? ~tx_ready_out : 1'b1;
  end
endmodule // host_link_model

// File: bench/tb.sv
// Self-checking bench for the key/value frame interpreter
`timescale 1ns/100ps
`define CHK(nm, sn, ex) begin comparisons++; if ((sn) !== (ex)) begin n_errors++; \
  $display("ERROR %s expected %h seen %h", nm, ex, sn); end end
module tb;
  import ufkv_pkg::*;
  typedef logic [7:0] q8_t[$];
  localparam int unsigned MOT = 20;
  localparam int unsigned WDG = 30;
  logic mclk_in = 1'b0;
  logic sys_rst_in = 1'b1;
  logic hb_pulse_in = 1'b0;
  logic nv_wdog_in = 1'b0;
  logic rx_ready_out, rx_valid, tx_valid_out, tx_ready, nv_wr_out, nv_wdog_out, estop_out;
  logic [7:0] rx_byte, tx_byte_out;
  remote_ctl_t ctl;
  apb_req_t req = '0;
  apb_rsp_t rsp;
  int n_errors = 0;
  int comparisons = 0;
  int cycles = 0;
  logic [31:0] rd;
  logic err;

  always #4 mclk_in = ~mclk_in;

  user_feedback_key_value_handler #(.MOTOR_CYCLES(MOT), .WDOG_CYCLES(WDG)) i_dut (
    .mclk_in(mclk_in), .sys_rst_in(sys_rst_in), .rx_byte_in(rx_byte), .rx_valid_in(rx_valid),
    .rx_ready_out(rx_ready_out), .tx_byte_out(tx_byte_out), .tx_valid_out(tx_valid_out),
    .tx_ready_in(tx_ready), .hb_pulse_in(hb_pulse_in), .nv_wdog_in(nv_wdog_in),
    .nv_wr_out(nv_wr_out), .nv_wdog_out(nv_wdog_out), .estop_out(estop_out),
    .remote_ctl_out(ctl), .apb_req_in(req), .apb_rsp_out(rsp));

  host_link_model i_host (
    .mclk_in(mclk_in), .rx_ready_in(rx_ready_out), .rx_byte_out(rx_byte),
    .rx_valid_out(rx_valid), .tx_byte_in(tx_byte_out), .tx_valid_in(tx_valid_out),
    .tx_ready_out(tx_ready));

  // Whole frame with the two running sums appended, low sum first
  function automatic q8_t frm(input logic [7:0] t, input logic [7:0] k, input logic [31:0] v);
    q8_t f;
    logic [7:0] s1, s2;
    f = '{8'h01, 8'h10, t, (t == 8'h30) ? 8'h05 : 8'h01, k};
    if (t == 8'h30) f = {f, v[7:0], v[15:8], v[23:16], v[31:24]};
    s1 = 8'h00;
    s2 = 8'h00;
    foreach (f[i]) begin
      s1 = s1 + f[i];
      s2 = s2 + s1;
    end
    return {f, s1, s2};
  endfunction

  task automatic tick(input int n);
    repeat (n) @(posedge mclk_in);
  endtask

  // Set frame, then two edges so the stored value is visible
  task automatic put(input logic [7:0] k, input logic [31:0] v);
    i_host.send(frm(8'h30, k, v));
    tick(2);
  endtask

  // One APB transfer: setup, access held until pready, then one idle edge
  // The idle edge keeps a following call from driving req twice in one step
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    req <= '{1'b1, 1'b0, w, a, d};
    @(posedge mclk_in);
    req.penable <= 1'b1;
    do @(posedge mclk_in); while (rsp.pready !== 1'b1);
    rd = rsp.prdata;
    err = rsp.pslverr;
    req <= '0;
    @(posedge mclk_in);
  endtask

  task automatic done(input string nm);
    $display("test %s done", nm);
  endtask

  task automatic t_reset();
    `CHK("auto_off", ctl.auto_off_en, 1'b1)
    `CHK("pause_en", {ctl.orient_pause_en, ctl.freefall_pause_en, ctl.inact_pause_en}, 3'h7)
    `CHK("wdog_en", nv_wdog_out, 1'b0)
    `CHK("pause_min", ctl.pause_minutes, 4'h1)
    done("reset");
  endtask

  task automatic t_config();
    for (int m = 0; m < 4; m++) begin
      put(8'h63, 32'(m));
      `CHK("disp_mode", ctl.disp_mode, 2'(m))
    end
    put(8'h50, 32'h0000_000A);
    `CHK("setting", ctl.inactivity_minutes_setting, 4'hA)
    `CHK("pause_min", ctl.pause_minutes, 4'hB)
    for (int k = 81; k < 85; k++) put(8'(k), 32'h0000_0000);
    `CHK("enables_off", {ctl.auto_off_en, ctl.orient_pause_en, ctl.freefall_pause_en,
      ctl.inact_pause_en}, 4'h0)
    for (int k = 81; k < 85; k++) put(8'(k), 32'h0000_0001);
    `CHK("enables_on", {ctl.auto_off_en, ctl.orient_pause_en, ctl.freefall_pause_en,
      ctl.inact_pause_en}, 4'hF)
    done("config");
  endtask

  // Corrupted checksum and out-of-range setting are both dropped and counted
  task automatic t_drop();
    q8_t f;
    logic [15:0] base;
    apb(1'b0, 8'h0C, 32'h0000_0000);
    base = rd[15:0];
    f = frm(8'h30, 8'h50, 32'h0000_0003);
    f[10] = ~f[10];
    i_host.send(f);
    tick(1);
    put(8'h50, 32'h0000_000B);
    `CHK("setting_kept", ctl.inactivity_minutes_setting, 4'hA)
    apb(1'b0, 8'h0C, 32'h0000_0000);
    `CHK("drop_cnt", rd[15:0], base + 16'h0002)
    done("drop");
  endtask

  task automatic t_motor();
    logic [7:0] k[3] = '{8'h0A, 8'h0B, 8'h0C};
    logic [1:0] e[3] = '{2'h2, 2'h1, 2'h3};
    for (int i = 0; i < 3; i++) begin
      put(k[i], 32'h0000_0001);
      `CHK("motor_on", {ctl.motor_left, ctl.motor_right}, e[i])
      tick(MOT - 2);
      `CHK("motor_hold", {ctl.motor_left, ctl.motor_right}, e[i])
      tick(1);
      `CHK("motor_off", {ctl.motor_left, ctl.motor_right}, 2'h0)
    end
    done("motor");
  endtask

  // Full signed value readback and the six-character boundary
  task automatic t_value();
    put(8'h05, 32'hFFFF_8000);
    put(8'h0C, 32'hFFFE_7960);
    apb(1'b1, 8'h00, 32'h0000_000C);
    apb(1'b0, 8'h04, 32'h0000_0000);
    `CHK("key_value", rd, 32'hFFFE_7960)
    apb(1'b0, 8'h08, 32'h0000_0000);
    `CHK("render_x", rd[2], 1'b1)
    put(8'h0C, 32'hFFFE_7961);
    apb(1'b0, 8'h08, 32'h0000_0000);
    `CHK("render_six", rd[2], 1'b0)
    `CHK("status_disp", rd[5:4], 2'h3)
    apb(1'b0, 8'h10, 32'h0000_0000);
    `CHK("unmapped_err", err, 1'b1)
    done("value");
  endtask

  // Queries answered through a stalling sink; key 0 gets no answer
  task automatic t_get();
    q8_t ex;
    logic [7:0] k[2] = '{8'h05, 8'h50};
    logic [31:0] v[2] = '{32'hFFFF_8000, 32'h0000_000A};
    i_host.slow = 1'b1;
    for (int j = 0; j < 2; j++) begin
      i_host.got.delete();
      i_host.send(frm(8'h32, k[j], 32'h0000_0000));
      for (int n = 0; n < 200 && i_host.got.size() < 11; n++) tick(1);
      ex = frm(8'h30, k[j], v[j]);
      `CHK("reply_len", i_host.got.size(), 11)
      foreach (ex[i]) `CHK("reply_byte", i_host.got[i], ex[i])
    end
    i_host.got.delete();
    i_host.send(frm(8'h32, 8'h00, 32'h0000_0000));
    tick(40);
    `CHK("no_reply", i_host.got.size(), 0)
    i_host.slow = 1'b0;
    done("get");
  endtask

  // Storage pulse stands one cycle; stop rises exactly WDG edges after enable or heartbeat
  task automatic t_wdog();
    i_host.send(frm(8'h30, 8'h55, 32'h0000_0001));
    tick(1);
    `CHK("nv_wr", nv_wr_out, 1'b1)
    `CHK("wdog_en", nv_wdog_out, 1'b1)
    tick(1);
    `CHK("nv_wr_pulse", nv_wr_out, 1'b0)
    tick(WDG - 2);
    `CHK("estop_early", estop_out, 1'b0)
    tick(1);
    `CHK("estop", estop_out, 1'b1)
    apb(1'b0, 8'h08, 32'h0000_0000);
    `CHK("status_stop", rd[1:0], 2'h3)
    hb_pulse_in <= 1'b1;
    tick(1);
    hb_pulse_in <= 1'b0;
    tick(2);
    `CHK("estop_clear", estop_out, 1'b0)
    tick(WDG);
    `CHK("estop_again", estop_out, 1'b1)
    put(8'h55, 32'h0000_0000);
    `CHK("wdog_off", {nv_wdog_out, estop_out}, 2'h0)
    tick(WDG + 10);
    `CHK("stays_off", estop_out, 1'b0)
    done("wdog");
  endtask

  // Mid-run reset restores defaults and reloads the stored watchdog enable
  task automatic t_nv();
    nv_wdog_in <= 1'b1;
    sys_rst_in <= 1'b1;
    tick(2);
    sys_rst_in <= 1'b0;
    tick(1);
    `CHK("disp_default", ctl.disp_mode, 2'h0)
    `CHK("pause_default", ctl.pause_minutes, 4'h1)
    tick(1);
    `CHK("nv_load", nv_wdog_out, 1'b1)
    tick(WDG + 1);
    `CHK("estop_nv", estop_out, 1'b1)
    done("nv");
  endtask

  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // A hang is cut short well beyond the few hundred cycles the tests need
  always @(posedge mclk_in) begin
    cycles++;
    if (cycles == 8000) begin
      n_errors++;
      tally_and_finish();
    end
  end

  initial begin
    tick(3);
    sys_rst_in <= 1'b0;
    tick(1);
    t_reset();
    t_config();
    t_drop();
    t_motor();
    t_value();
    t_get();
    t_wdog();
    t_nv();
    tally_and_finish();
  end
endmodule // tb
